/* include/tpair_pkg.sv */
// Constants, field layouts and carrier types for the cascadable timer pair
// ****************************************************************
// What this block does
// R1: Buffered pulse mode, counting: duty/period writes go to shadow, active value kept.
// R2: Buffered pulse mode: shadow moves to active compare when low channel pulse fires.
// R3: Buffered: reading duty or period returns shadow, the last written value.
// R4: Buffered and stopped: duty/period write updates shadow and active together.
// R5: Unbuffered pulse mode: duty/period write updates active compare immediately.
// R6: Unbuffered value below count: no toggle until counter wraps and matches.
// R7: Unbuffered value equal to count: match is detected right after the write.
// R8: Cascade select 1 joins both channels; only high channel mode settings apply. The pulse output still idles at the low mode initial-level bit.
// R9: 16-bit timer when high mode 00/01, high ext select 0; high divider clocks it.
// R10: 16-bit compare: low byte from low period, high byte from high period.
// R11: High period write commits both bytes together; low byte write alone does nothing.
// R12: Software writes low period byte first, then high period byte.
// R13: High mode writes ignored while high run set; setup with both runs clear.
// R14: 16-bit running: count each tick; on match pulse cascade irq, clear, continue.
// R15: Clearing high run stops 16-bit counter and clears it to zero.
// R16: 16-bit buffered, counting: commit waits in shadow until next match loads it.
// R17: 16-bit buffered and stopped: commit updates shadow and active at once.
// R18: 16-bit unbuffered: commit immediate; value below count matches only after wrap.
// R19: 16-bit unbuffered: value equal to count matches right after commit.
// R20: Reading combined period returns last written value regardless of buffering.
// R21: Clock select maps gear divisors; slow settings use low-frequency clock for 000,001,111.
// R22: 16-bit event mode counts on each falling edge of the event input pin.
// R23: Pulse mode toggles on duty match, again on period match, irq on period.
// R24: Pulse mode is low mode field 1 with cascade select 0.
// R25: Pulse output idles at the initial-level bit before start and after stop.
// R26: Clearing low run stops, clears counter and returns output to idle level.
// R27: 16-bit counter wraps from all ones to zero and matching continues.
// ****************************************************************
package tpair_pkg;

    // ****************************************************************
    // Register map, one 32-bit word each
    // ****************************************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_LMODE = 8'h04;
    localparam logic [7:0] REG_HMODE = 8'h08;
    localparam logic [7:0] REG_DUTY = 8'h0C;
    localparam logic [7:0] REG_LPER = 8'h10;
    localparam logic [7:0] REG_HPER = 8'h14;
    localparam logic [7:0] REG_SYSC = 8'h18;
    localparam logic [7:0] REG_STAT = 8'h1C;

    // ****************************************************************
    // Field values and reset values
    // ****************************************************************
    localparam logic [1:0] MODE_PULSE = 2'h1;
    localparam logic [7:0] CMP_RST = 8'hFF;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [2:0] DIV_FS16 = 3'h0;
    localparam logic [2:0] DIV_FS8 = 3'h1;
    localparam logic [2:0] DIV_FS4 = 3'h7;

    typedef enum logic [2:0] {
        OP_IDLE = 3'b001,
        OP_PULSE = 3'b010,
        OP_CASC = 3'b100
    } op_state_t;

    typedef struct packed {
        logic cascade_select;
        logic high_run_bit;
        logic low_run_bit;
    } ctrl_t;

    typedef struct packed {
        logic init_level;
        logic dbuf_on;
        logic [2:0] clk_div;
        logic ext_sel;
        logic [1:0] mode_field;
    } mode_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_t;

    typedef struct packed {
        ctrl_t ctrl;
        mode_t lmode;
        mode_t hmode;
        logic [1:0] sysc;
        logic [7:0] duty_sh;
        logic [7:0] duty_act;
        logic [7:0] lo_latch;
        logic [15:0] per_sh;
        logic [15:0] per_act;
        logic [15:0] cnt;
        logic chk;
        logic pout;
        logic lirq;
        logic cirq;
        logic [10:0] pre;
        logic [3:0] fs_cnt;
        logic [2:0] fs_s;
        logic [2:0] ev_s;
        op_state_t op;
        wb_rsp_t rsp;
    } blk_state_t;

endpackage

/* rtl/timer_pair.sv */
// Cascadable 8-bit timer pair with pulse generator and 16-bit timer/event mode
`timescale 1ns/1ps
module timer_pair
    import tpair_pkg::*;
(
    input wire logic clk, // 10 MHz gear clock
    input wire logic resetn, // Async reset, active low
    input wire wb_req_t wb_req, // Wishbone classic request
    output wb_rsp_t wb_rsp, // Wishbone answer, registered
    input wire logic low_freq_clock, // Slow clock pin, asynchronous
    input wire logic event_input_pin, // Event pin, asynchronous
    output logic pulse_out_pin, // Pulse output, registered
    output logic low_channel_irq, // One-cycle pulse on period match
    output logic cascade_irq // One-cycle pulse on 16-bit match
);

    // ****************************************************************
    // Source clock selection
    // ****************************************************************
    function automatic logic src_tick(input logic [2:0] code, input logic slow,
                                      input logic [10:0] pre, input logic fs_edge,
                                      input logic [3:0] fs_cnt);
        logic t;
        t = 1'b0;
        if (slow && code == DIV_FS16)
        begin
            t = fs_edge && (&fs_cnt);
        end
        else if (slow && code == DIV_FS8)
        begin
            t = fs_edge && (&fs_cnt[2:0]);
        end
        else if (slow && code == DIV_FS4)
        begin
            t = fs_edge && (&fs_cnt[1:0]);
        end
        else
        begin
            case (code)
                3'h0: t = &pre[10:0];
                3'h1: t = &pre[9:0];
                3'h2: t = &pre[7:0];
                3'h3: t = &pre[5:0];
                3'h4: t = &pre[3:0];
                3'h5: t = &pre[1:0];
                3'h6: t = pre[0];
                default: t = 1'b1;
            endcase
        end
        return t;
    endfunction

    blk_state_t s_r;
    blk_state_t s_nxt;

    logic wr;
    logic fs_edge;
    logic ev_fall;
    logic slow;
    logic ltick;
    logic htick;
    logic imm_l;
    logic imm_h;
    logic dmatch;
    logic pmatch;
    logic cmatch;
    logic [7:0] d;

    assign wr = wb_req.cyc && wb_req.stb && wb_req.we && s_r.rsp.ack && wb_req.sel[0];
    assign d = wb_req.dat[7:0];
    assign fs_edge = s_r.fs_s[1] && !s_r.fs_s[2];
    assign ev_fall = !s_r.ev_s[1] && s_r.ev_s[2]; // see R22
    assign slow = |s_r.sysc;
    assign ltick = s_r.lmode.ext_sel ? ev_fall
                 : src_tick(s_r.lmode.clk_div, slow, s_r.pre, fs_edge, s_r.fs_cnt);
    assign htick = s_r.hmode.ext_sel ? ev_fall
                 : src_tick(s_r.hmode.clk_div, slow, s_r.pre, fs_edge, s_r.fs_cnt); // see R21
    assign imm_l = !s_r.lmode.dbuf_on || !s_r.ctrl.low_run_bit;
    assign imm_h = !s_r.hmode.dbuf_on || !s_r.ctrl.high_run_bit;
    // Match is only looked at once after the count or compare moves
    assign dmatch = s_r.chk && s_r.cnt[7:0] == s_r.duty_act;
    assign pmatch = s_r.chk && s_r.cnt[7:0] == s_r.per_act[7:0];
    assign cmatch = s_r.chk && s_r.cnt == s_r.per_act; // see R10

    assign wb_rsp = s_r.rsp;
    assign pulse_out_pin = s_r.pout;
    assign low_channel_irq = s_r.lirq;
    assign cascade_irq = s_r.cirq;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.lirq = 1'b0;
        s_nxt.cirq = 1'b0;
        s_nxt.chk = 1'b0;
        s_nxt.pre = 11'(s_r.pre + 11'h001);
        s_nxt.fs_s = {s_r.fs_s[1:0], low_freq_clock};
        s_nxt.ev_s = {s_r.ev_s[1:0], event_input_pin};
        if (fs_edge)
        begin
            s_nxt.fs_cnt = 4'(s_r.fs_cnt + 4'h1);
        end

        if (s_r.ctrl.cascade_select)
        begin
            // Low channel settings do not matter here
            s_nxt.op = s_r.hmode.mode_field[1] ? OP_IDLE : OP_CASC; // see R8, R9
        end
        else
        begin
            s_nxt.op = (s_r.lmode.mode_field == MODE_PULSE) ? OP_PULSE : OP_IDLE; // see R24
        end

        case (s_r.op)
            OP_PULSE:
            begin
                s_nxt.cnt[15:8] = 8'h00;
                if (!s_r.ctrl.low_run_bit)
                begin
                    s_nxt.cnt = 16'h0000; // see R26
                    s_nxt.pout = s_r.lmode.init_level; // see R25
                end
                else if (pmatch)
                begin
                    s_nxt.pout = s_r.pout ^ dmatch ^ 1'b1; // see R23
                    s_nxt.lirq = 1'b1;
                    s_nxt.cnt = 16'h0000;
                    s_nxt.chk = 1'b1;
                    if (s_r.lmode.dbuf_on)
                    begin
                        s_nxt.duty_act = s_r.duty_sh; // see R2
                        s_nxt.per_act[7:0] = s_r.per_sh[7:0];
                    end
                end
                else
                begin
                    s_nxt.pout = s_r.pout ^ dmatch; // see R23
                    if (ltick)
                    begin
                        // Wraps past 0xFF, so a lower compare waits a lap
                        s_nxt.cnt[7:0] = 8'(s_r.cnt[7:0] + 8'h01); // see R6
                        s_nxt.chk = 1'b1;
                    end
                end
            end
            OP_CASC:
            begin
                s_nxt.pout = s_r.lmode.init_level;
                if (!s_r.ctrl.high_run_bit)
                begin
                    s_nxt.cnt = 16'h0000; // see R15
                end
                else if (cmatch)
                begin
                    s_nxt.cirq = 1'b1; // see R14
                    s_nxt.cnt = 16'h0000;
                    s_nxt.chk = 1'b1;
                    if (s_r.hmode.dbuf_on)
                    begin
                        s_nxt.per_act = s_r.per_sh; // see R16
                    end
                end
                else if (htick)
                begin
                    s_nxt.cnt = 16'(s_r.cnt + 16'h0001); // see R14, R27, R18
                    s_nxt.chk = 1'b1;
                end
            end
            default:
            begin
                s_nxt.cnt = 16'h0000;
                s_nxt.pout = s_r.lmode.init_level; // see R25
            end
        endcase

        // Register writes land at the edge where the master sees ack
        if (wr)
        begin
            if (wb_req.adr == REG_CTRL)
            begin
                s_nxt.ctrl = ctrl_t'(d[2:0]);
            end
            else if (wb_req.adr == REG_LMODE)
            begin
                if (!s_r.ctrl.low_run_bit && !s_r.ctrl.high_run_bit)
                begin
                    s_nxt.lmode = mode_t'(d);
                end
            end
            else if (wb_req.adr == REG_HMODE)
            begin
                if (!s_r.ctrl.high_run_bit && !s_r.ctrl.low_run_bit)
                begin
                    s_nxt.hmode = mode_t'(d); // see R13
                end
            end
            else if (wb_req.adr == REG_DUTY)
            begin
                s_nxt.duty_sh = d; // see R1
                if (imm_l)
                begin
                    s_nxt.duty_act = d; // see R4, R5
                end
                s_nxt.chk = 1'b1; // see R7
            end
            else if (wb_req.adr == REG_LPER)
            begin
                s_nxt.lo_latch = d;
                if (!s_r.ctrl.cascade_select)
                begin
                    s_nxt.per_sh[7:0] = d; // see R1
                    if (imm_l)
                    begin
                        s_nxt.per_act[7:0] = d; // see R4, R5
                    end
                    s_nxt.chk = 1'b1; // see R7
                end
            end
            else if (wb_req.adr == REG_HPER)
            begin
                // Both bytes commit together, low byte from the latch
                s_nxt.per_sh = {d, s_r.lo_latch}; // see R11, R16
                if (imm_h)
                begin
                    s_nxt.per_act = {d, s_r.lo_latch}; // see R17, R18
                end
                s_nxt.chk = 1'b1; // see R19
            end
            else if (wb_req.adr == REG_SYSC)
            begin
                s_nxt.sysc = d[1:0];
            end
        end

        // ****************************************************************
        // Bus answer, one wait state, unmapped reads give zero
        // ****************************************************************
        s_nxt.rsp.ack = wb_req.cyc && wb_req.stb && !s_r.rsp.ack;
        s_nxt.rsp.dat = 32'h0000_0000;
        if (wb_req.adr == REG_CTRL)
        begin
            s_nxt.rsp.dat[2:0] = s_r.ctrl;
        end
        else if (wb_req.adr == REG_LMODE)
        begin
            s_nxt.rsp.dat[7:0] = s_r.lmode;
        end
        else if (wb_req.adr == REG_HMODE)
        begin
            s_nxt.rsp.dat[7:0] = s_r.hmode;
        end
        else if (wb_req.adr == REG_DUTY)
        begin
            s_nxt.rsp.dat[7:0] = s_r.duty_sh; // see R3
        end
        else if (wb_req.adr == REG_LPER)
        begin
            s_nxt.rsp.dat[7:0] = s_r.lo_latch; // see R3, R20
        end
        else if (wb_req.adr == REG_HPER)
        begin
            s_nxt.rsp.dat[7:0] = s_r.per_sh[15:8]; // see R20
        end
        else if (wb_req.adr == REG_SYSC)
        begin
            s_nxt.rsp.dat[1:0] = s_r.sysc;
        end
        else if (wb_req.adr == REG_STAT)
        begin
            s_nxt.rsp.dat[20:0] = {s_r.op, s_r.cirq, s_r.pout, s_r.cnt};
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_r <= '0;
            s_r.lmode <= mode_t'(MODE_RST);
            s_r.hmode <= mode_t'(MODE_RST);
            s_r.duty_sh <= CMP_RST;
            s_r.duty_act <= CMP_RST;
            s_r.lo_latch <= CMP_RST;
            s_r.per_sh <= {CMP_RST, CMP_RST};
            s_r.per_act <= {CMP_RST, CMP_RST};
            s_r.op <= OP_IDLE;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    AST_PULSE_PERIOD: assert property ( // see R23
        s_r.op == OP_PULSE && s_r.ctrl.low_run_bit && pmatch
        |=> low_channel_irq && s_r.cnt == 16'h0000
            && pulse_out_pin == ($past(pulse_out_pin) ^ !$past(dmatch))
    ) else $error("period match did not toggle, clear and pulse irq");

    AST_PULSE_RELOAD: assert property ( // see R2
        s_r.op == OP_PULSE && s_r.ctrl.low_run_bit && pmatch && s_r.lmode.dbuf_on && !wr
        |=> s_r.duty_act == $past(s_r.duty_sh) && s_r.per_act[7:0] == $past(s_r.per_sh[7:0])
    ) else $error("shadow not loaded at period match");

    AST_DUTY_HELD: assert property ( // see R1
        wr && wb_req.adr == REG_DUTY && s_r.lmode.dbuf_on && s_r.ctrl.low_run_bit && !pmatch
        |=> s_r.duty_act == $past(s_r.duty_act) && s_r.duty_sh == $past(d)
    ) else $error("buffered duty write changed active value");

    AST_DUTY_DIRECT: assert property ( // see R4
        wr && wb_req.adr == REG_DUTY && imm_l
        |=> s_r.duty_act == $past(d)
    ) else $error("direct duty write not applied");

    AST_CASC_MATCH: assert property ( // see R14
        s_r.op == OP_CASC && s_r.ctrl.high_run_bit && cmatch
        |=> cascade_irq && s_r.cnt == 16'h0000 ##1 !cascade_irq
    ) else $error("16-bit match did not pulse irq and clear");

    AST_CASC_STOP: assert property ( // see R15
        s_r.op == OP_CASC && !s_r.ctrl.high_run_bit |=> s_r.cnt == 16'h0000
    ) else $error("stopped 16-bit counter not cleared");

    AST_LOW_ONLY: assert property ( // see R11
        wr && wb_req.adr == REG_LPER && s_r.ctrl.cascade_select && !cmatch
        |=> s_r.per_act == $past(s_r.per_act) && s_r.per_sh == $past(s_r.per_sh)
    ) else $error("low period byte alone changed the compare");

    AST_MODE_LOCK: assert property ( // see R13
        wr && wb_req.adr == REG_HMODE && s_r.ctrl.high_run_bit
        |=> s_r.hmode == $past(s_r.hmode)
    ) else $error("high mode written while running");

    AST_CASC_DIRECT: assert property ( // see R17
        wr && wb_req.adr == REG_HPER && imm_h
        |=> s_r.per_act == {$past(d), $past(s_r.lo_latch)} && s_r.per_sh == s_r.per_act
    ) else $error("direct 16-bit commit not applied");

    AST_CASC_SHADOW: assert property ( // see R16
        s_r.op == OP_CASC && wr && wb_req.adr == REG_HPER && !imm_h && !cmatch
        |=> s_r.per_act == $past(s_r.per_act) && s_r.per_sh == {$past(d), $past(s_r.lo_latch)}
    ) else $error("buffered 16-bit commit changed active compare");

    AST_CASC_COUNT: assert property ( // see R14, R27
        s_r.op == OP_CASC && s_r.ctrl.high_run_bit && !cmatch && htick
        |=> s_r.cnt == 16'($past(s_r.cnt) + 16'h0001)
    ) else $error("16-bit counter missed a source tick");

    AST_CASC_NO_PULSE: assert property ( // see R8
        s_r.ctrl.cascade_select |=> s_r.op != OP_PULSE
    ) else $error("pulse mode active while cascaded");

    AST_NO_STRAY_IRQ: assert property ( // see R26, R15
        !s_r.ctrl.low_run_bit && !s_r.ctrl.high_run_bit
        |=> !low_channel_irq && !cascade_irq
    ) else $error("irq raised with both channels stopped");

    AST_IDLE_LEVEL: assert property ( // see R25
        s_r.op == OP_PULSE && !s_r.ctrl.low_run_bit
        |=> pulse_out_pin == $past(s_r.lmode.init_level) && s_r.cnt[7:0] == 8'h00
    ) else $error("stopped pulse output not at idle level");

endmodule

/* test/event_partner.sv */
// Far-side model: event source pin, free slow clock and pulse output watcher
`timescale 1ns/1ps
module event_partner (
    input wire logic clk, // Gear clock, paces the edges
    input wire logic pulse_out_pin, // Watched pulse output
    output logic event_input_pin, // Event pin, idles high
    output logic low_freq_clock, // Free-running slow clock
    output int n_toggle // Pulse output edges seen
);
    logic pout_q;
    logic [3:0] lf_cnt;

    initial
    begin
        event_input_pin = 1'b1;
        low_freq_clock = 1'b0;
        n_toggle = 0;
        pout_q = 1'b0;
        lf_cnt = 4'h0;
    end

    // Slow oscillator runs free, as a crystal would
    always @(posedge clk)
    begin
        lf_cnt <= lf_cnt + 4'h1;
        if (lf_cnt == 4'hF)
            low_freq_clock <= ~low_freq_clock;
        pout_q <= pulse_out_pin;
        if (pulse_out_pin !== pout_q)
            n_toggle <= n_toggle + 1;
    end

    // Low held four cycles, high five, above the two-cycle minimum width
    task automatic send_edges(input int n);
        repeat (n)
        begin
            @(posedge clk);
            event_input_pin <= 1'b0;
            repeat (4) @(posedge clk);
            event_input_pin <= 1'b1;
            repeat (4) @(posedge clk);
        end
    endtask
endmodule

/* test/tb_cascadable_timer_pair_ppg.sv */
// Self-checking bench for the cascadable timer pair
`timescale 1ns/1ps
`define CHECK(got, exp) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("ERROR at %0t: got %h expected %h", $time, (got), (exp)); \
        end \
    end

module tb_cascadable_timer_pair_ppg;
    import tpair_pkg::*;

    logic clk;
    logic resetn;
    wb_req_t wb_req;
    wb_rsp_t wb_rsp;
    logic low_freq_clock;
    logic event_input_pin;
    logic pulse_out_pin;
    logic low_channel_irq;
    logic cascade_irq;
    int n_toggle;
    int n_mismatch;
    int tests_run;
    int cyc_cnt;
    int t_irq;
    logic [31:0] rd;

    timer_pair DUT (
        .clk(clk),
        .resetn(resetn),
        .wb_req(wb_req),
        .wb_rsp(wb_rsp),
        .low_freq_clock(low_freq_clock),
        .event_input_pin(event_input_pin),
        .pulse_out_pin(pulse_out_pin),
        .low_channel_irq(low_channel_irq),
        .cascade_irq(cascade_irq)
    );

    event_partner partner (
        .clk(clk),
        .pulse_out_pin(pulse_out_pin),
        .event_input_pin(event_input_pin),
        .low_freq_clock(low_freq_clock),
        .n_toggle(n_toggle)
    );

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial
    begin
        cyc_cnt = 0;
        forever @(posedge clk) cyc_cnt <= cyc_cnt + 1;
    end

    task automatic final_report;
        if (n_mismatch == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ********************************
    // Bus and wait helpers
    // ********************************
    task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] dat);
        int n;
        wb_req.cyc <= 1'b1;
        wb_req.stb <= 1'b1;
        wb_req.we <= we;
        wb_req.adr <= adr;
        wb_req.sel <= 4'hF;
        wb_req.dat <= {24'h00_0000, dat};
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wb_rsp.ack !== 1'b1 && n < 64);
        if (n >= 64)
        begin
            n_mismatch++;
            final_report();
        end
        rd = wb_rsp.dat;
        wb_req.cyc <= 1'b0;
        wb_req.stb <= 1'b0;
        wb_req.we <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
        bus(1'b1, adr, dat);
    endtask

    task automatic rd_reg(input logic [7:0] adr);
        bus(1'b0, adr, 8'h00);
    endtask

    // Stamps the cycle of the next irq pulse; a lost irq ends the run
    task automatic wait_irq(input bit casc);
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while ((casc ? cascade_irq : low_channel_irq) !== 1'b1 && n < 3000);
        if (n >= 3000)
        begin
            n_mismatch++;
            final_report();
        end
        t_irq = cyc_cnt;
    endtask

    // ********************************
    // Scenarios
    // ********************************
    task automatic t_reset;
        rd_reg(REG_LPER);
        `CHECK(rd, 32'h0000_00FF);
        rd_reg(8'h40);
        `CHECK(rd, 32'h0000_0000);
    endtask

    task automatic t_pulse;
        int t0;
        int i1;
        wr(REG_LMODE, 8'h39);
        wr(REG_DUTY, 8'h04);
        wr(REG_LPER, 8'h0A);
        wr(REG_CTRL, 8'h01);
        wait_irq(1'b0);
        repeat (3) @(posedge clk);
        t0 = n_toggle;
        wait_irq(1'b0);
        i1 = t_irq;
        repeat (3) @(posedge clk);
        `CHECK(n_toggle - t0, 2);
        wait_irq(1'b0);
        i1 = t_irq - i1;
        wr(REG_LPER, 8'h12);
        wait_irq(1'b0);
        t0 = t_irq;
        wait_irq(1'b0);
        `CHECK(t_irq - t0, i1 + 8);
        wr(REG_CTRL, 8'h00);
        repeat (3) @(posedge clk);
        `CHECK(pulse_out_pin, 1'b0);
        rd_reg(REG_STAT);
        `CHECK(rd[15:0], 16'h0000);
        wr(REG_LMODE, 8'hB9);
        repeat (3) @(posedge clk);
        `CHECK(pulse_out_pin, 1'b1);
    endtask

    task automatic t_dbuf;
        int ta;
        int i1;
        wr(REG_LMODE, 8'h79);
        wr(REG_LPER, 8'h0A);
        wr(REG_CTRL, 8'h01);
        wait_irq(1'b0);
        ta = t_irq;
        wait_irq(1'b0);
        i1 = t_irq - ta;
        ta = t_irq;
        wr(REG_LPER, 8'h20);
        rd_reg(REG_LPER);
        `CHECK(rd, 32'h0000_0020);
        wait_irq(1'b0);
        `CHECK(t_irq - ta, i1);
        ta = t_irq;
        wr(REG_DUTY, 8'h06);
        rd_reg(REG_DUTY);
        `CHECK(rd, 32'h0000_0006);
        wait_irq(1'b0);
        `CHECK(t_irq - ta, i1 + 22);
        wr(REG_CTRL, 8'h00);
    endtask

    task automatic t_casc;
        int ta;
        int i1;
        wr(REG_HMODE, 8'h38);
        wr(REG_LPER, 8'h10);
        wr(REG_HPER, 8'h01);
        wr(REG_CTRL, 8'h06);
        wait_irq(1'b1);
        ta = t_irq;
        wait_irq(1'b1);
        i1 = t_irq - ta;
        ta = t_irq;
        wr(REG_LPER, 8'h30);
        wait_irq(1'b1);
        `CHECK(t_irq - ta, i1);
        wr(REG_HPER, 8'h01);
        wait_irq(1'b1);
        ta = t_irq;
        wait_irq(1'b1);
        `CHECK(t_irq - ta, i1 + 32);
        rd_reg(REG_LPER);
        `CHECK(rd, 32'h0000_0030);
        wr(REG_HMODE, 8'h00);
        rd_reg(REG_HMODE);
        `CHECK(rd, 32'h0000_0038);
        wr(REG_CTRL, 8'h04);
        repeat (3) @(posedge clk);
        rd_reg(REG_STAT);
        `CHECK(rd[15:0], 16'h0000);
        // Buffered 16-bit: stopped commit is direct, running commit waits a match
        wr(REG_HMODE, 8'h78);
        wr(REG_LPER, 8'h08);
        wr(REG_HPER, 8'h00);
        wr(REG_CTRL, 8'h06);
        wait_irq(1'b1);
        ta = t_irq;
        wait_irq(1'b1);
        i1 = t_irq - ta;
        `CHECK(i1, 9);
        ta = t_irq;
        wr(REG_LPER, 8'h20);
        wr(REG_HPER, 8'h00);
        wait_irq(1'b1);
        `CHECK(t_irq - ta, i1);
        ta = t_irq;
        wait_irq(1'b1);
        `CHECK(t_irq - ta, i1 + 24);
        wr(REG_CTRL, 8'h04);
    endtask

    // Slow prescale, code 111: four slow-clock rises per tick, 32 cycles each
    task automatic t_slow;
        int ta;
        wr(REG_SYSC, 8'h01);
        wr(REG_LMODE, 8'h39);
        wr(REG_LPER, 8'h02);
        wr(REG_CTRL, 8'h01);
        wait_irq(1'b0);
        ta = t_irq;
        wait_irq(1'b0);
        `CHECK(t_irq - ta, 2 * 4 * 32);
        wr(REG_CTRL, 8'h00);
        wr(REG_SYSC, 8'h00);
    endtask

    task automatic t_event;
        wr(REG_HMODE, 8'h3C);
        wr(REG_LPER, 8'h03);
        wr(REG_HPER, 8'h00);
        wr(REG_CTRL, 8'h06);
        partner.send_edges(2);
        rd_reg(REG_STAT);
        `CHECK(rd[15:0], 16'h0002);
        partner.send_edges(1);
        rd_reg(REG_STAT);
        `CHECK(rd[15:0], 16'h0000);
        wr(REG_CTRL, 8'h00);
    endtask

    // Whole run needs a few thousand cycles; 50000 leaves wide margin
    initial
    begin
        #5_000_000;
        n_mismatch++;
        final_report();
    end

    initial
    begin
        n_mismatch = 0;
        tests_run = 0;
        resetn = 1'b0;
        wb_req = '0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_pulse();
        t_dbuf();
        t_casc();
        t_event();
        t_slow();
        final_report();
    end
endmodule
